// *** src/intc_pkg.sv ***
package intc_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int NSRC = 32;
  localparam int NLVL = 8;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [8:0] SMR_BASE  = 9'h000;
  localparam logic [8:0] SVR_BASE  = 9'h080;
  localparam logic [8:0] IVR_OFS   = 9'h100;
  localparam logic [8:0] FVR_OFS   = 9'h104;
  localparam logic [8:0] ISR_OFS   = 9'h108;
  localparam logic [8:0] IPR_OFS   = 9'h10C;
  localparam logic [8:0] IMR_OFS   = 9'h110;
  localparam logic [8:0] CISR_OFS  = 9'h114;
  localparam logic [8:0] IECR_OFS  = 9'h120;
  localparam logic [8:0] IDCR_OFS  = 9'h124;
  localparam logic [8:0] ICCR_OFS  = 9'h128;
  localparam logic [8:0] ISCR_OFS  = 9'h12C;
  localparam logic [8:0] EOICR_OFS = 9'h130;
  localparam logic [8:0] SPU_OFS   = 9'h134;
  localparam logic [8:0] DCR_OFS   = 9'h138;
  localparam logic [8:0] FFER_OFS  = 9'h140;
  localparam logic [8:0] FFDR_OFS  = 9'h144;
  localparam logic [8:0] FFSR_OFS  = 9'h148;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int SMR_PRIO_LSB = 0;
  localparam int SMR_TYPE_LSB = 5;
  localparam int DCR_PROT_BIT = 0;
  localparam int DCR_GMSK_BIT = 1;
  localparam int CISR_FAST_BIT = 0;
  localparam int CISR_IRQ_BIT = 1;
  localparam logic [31:0] SPU_RST = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    TYP_LOW_LEVEL  = 2'b00,
    TYP_FALL_EDGE  = 2'b01,
    TYP_HIGH_LEVEL = 2'b10,
    TYP_RISE_EDGE  = 2'b11
  } src_type_t;

endpackage

// *** src/arb_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface arb_if;
  logic [intc_pkg::NSRC-1:0]      cand;
  logic [intc_pkg::NSRC-1:0][2:0] prio;
  logic                           any;
  logic [4:0]                     idx;
  logic [2:0]                     lvl;
  modport ctl (output cand, prio, input any, idx, lvl);
  modport arb (input cand, prio, output any, idx, lvl);
endinterface
`default_nettype wire

// *** src/prio_arbiter.sv ***
`timescale 1ns/10ps
`default_nettype none
module prio_arbiter (
  arb_if.arb a
);
  logic       any;
  logic [4:0] idx;
  logic [2:0] lvl;

  // Highest level wins, lowest index breaks a tie
  always_comb begin
    any = 1'b0;
    idx = 5'h0;
    lvl = 3'h0;
    for (int i = 0; i < intc_pkg::NSRC; i++) begin
      if (a.cand[i] && (!any || a.prio[i] > lvl)) begin
        any = 1'b1;
        idx = 5'(i);
        lvl = a.prio[i];
      end
    end
  end

  assign a.any = any;
  assign a.idx = idx;
  assign a.lvl = lvl;
endmodule
`default_nettype wire

// *** src/vectored_priority_interrupt_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
module vectored_priority_interrupt_ctrl #(
  parameter logic [31:0] EXT_SRC     = 32'hFE00_0000,
  parameter bit          FAST_PIN_PRESENT = 1'b1,
  parameter int          NSYS        = 4
) (
  input  wire logic                sys_clk_in,
  input  wire logic                sys_rst_in,
  input  wire logic [31:0]         s_axi_awaddr_in,
  input  wire logic                s_axi_awvalid_in,
  output logic                     s_axi_awready_out,
  input  wire logic [31:0]         s_axi_wdata_in,
  input  wire logic [3:0]          s_axi_wstrb_in,
  input  wire logic                s_axi_wvalid_in,
  output logic                     s_axi_wready_out,
  output logic [1:0]               s_axi_bresp_out,
  output logic                     s_axi_bvalid_out,
  input  wire logic                s_axi_bready_in,
  input  wire logic [31:0]         s_axi_araddr_in,
  input  wire logic                s_axi_arvalid_in,
  output logic                     s_axi_arready_out,
  output logic [31:0]              s_axi_rdata_out,
  output logic [1:0]               s_axi_rresp_out,
  output logic                     s_axi_rvalid_out,
  input  wire logic                s_axi_rready_in,
  input  wire logic                fast_request_pin_in,
  input  wire logic [31:0]         external_request_pins_in,
  input  wire logic [NSYS-1:0]     system_irq_in,
  input  wire logic [31:0]         peripheral_irq_in,
  output logic                     fast_request_out_n,
  output logic                     normal_request_out_n,
  output logic                     idle_wake_out
);
  localparam int N = intc_pkg::NSRC;
  localparam int L = intc_pkg::NLVL;

  typedef struct packed {
    logic [N-1:0]                        s1, s2, s3, filt, prev, edg, imr, ffr;
    logic [N-1:0][2:0]                   prio;
    intc_pkg::src_type_t [N-1:0]         typ;
    logic [N-1:0][31:0]                  svr;
    logic [31:0]                         spu;
    logic                                prot, gmsk;
    logic [L-1:0][2:0]                   slvl;
    logic [L-1:0][4:0]                   ssrc;
    logic [3:0]                          depth;
    logic                                aw_have, w_have, wbad, bvalid, rvalid;
    logic [8:0]                          waddr;
    logic [31:0]                         wdata, rdata;
    logic [3:0]                          wstrb;
    logic [1:0]                          bresp, rresp;
    logic                                fast_n, irq_n, wake;
  } state_t;

  state_t q, n;
  arb_if  arb ();

  prio_arbiter u_arb (
    .a (arb)
  );

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[8*b +: 8] = d[8*b +: 8];
    end
    return r;
  endfunction

  function automatic logic reg_ok(input logic [8:0] a);
    if (a[1:0] != 2'b00) return 1'b0;
    if (!a[8]) return 1'b1;
    case (a)
      intc_pkg::IVR_OFS, intc_pkg::FVR_OFS, intc_pkg::ISR_OFS, intc_pkg::IPR_OFS,
      intc_pkg::IMR_OFS, intc_pkg::CISR_OFS, intc_pkg::IECR_OFS, intc_pkg::IDCR_OFS,
      intc_pkg::ICCR_OFS, intc_pkg::ISCR_OFS, intc_pkg::EOICR_OFS, intc_pkg::SPU_OFS,
      intc_pkg::DCR_OFS, intc_pkg::FFER_OFS, intc_pkg::FFDR_OFS,
      intc_pkg::FFSR_OFS: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // ****************************************
  // Source conditioning
  // ****************************************
  logic [N-1:0] pin_raw, src, act, em, inv, ipr, rise, ff_all;
  logic [N-1:0] pin_m, ext_m;

  assign pin_raw = {external_request_pins_in[N-1:1], fast_request_pin_in};
  assign ext_m   = {EXT_SRC[N-1:2], 2'b00};
  assign pin_m   = {EXT_SRC[N-1:2], 1'b0, 1'b1};
  assign src     = (ext_m & q.filt) |
                   (~ext_m & {peripheral_irq_in[N-1:2],
                              |system_irq_in,
                              FAST_PIN_PRESENT & q.filt[0]});

  always_comb begin
    for (int i = 0; i < N; i++) begin
      em[i]  = q.typ[i][0];
      inv[i] = pin_m[i] & ~q.typ[i][1];
    end
  end

  assign act    = src ^ inv;
  assign rise   = act & ~q.prev;
  assign ipr    = (em & q.edg) | (~em & act);
  assign ff_all = q.ffr | {{(N-1){1'b0}}, 1'b1};

  // ****************************************
  // Priority and requests
  // ****************************************
  logic       fast_raw, irq_raw;
  logic [2:0] top_idx;
  logic [4:0] cur_src;

  assign arb.cand = ipr & q.imr & ~ff_all;
  assign arb.prio = q.prio;
  assign top_idx  = 3'(q.depth - 4'd1);
  assign cur_src  = (q.depth == 4'd0) ? 5'h0 : q.ssrc[top_idx];
  assign irq_raw  = arb.any && (q.depth == 4'd0 || arb.lvl > q.slvl[top_idx]);
  assign fast_raw = |(ipr & q.imr & ff_all);

  // ****************************************
  // Bus handshakes
  // ****************************************
  logic rd_go, wr_go, wr_hit;
  assign s_axi_awready_out = !q.aw_have && !q.bvalid;
  assign s_axi_wready_out  = !q.w_have && !q.bvalid;
  assign s_axi_arready_out = !q.rvalid;
  assign rd_go  = s_axi_arvalid_in && s_axi_arready_out;
  assign wr_go  = q.aw_have && q.w_have && !q.bvalid;
  assign wr_hit = wr_go && !q.wbad && reg_ok(q.waddr);

  // ****************************************
  // Read mux
  // ****************************************
  logic [8:0]  ra;
  logic [31:0] rd_val;
  logic        rd_ok;

  always_comb begin
    ra     = s_axi_araddr_in[8:0];
    rd_val = 32'h0000_0000;
    rd_ok  = (s_axi_araddr_in[31:9] == 23'h0) && reg_ok(ra);
    if (ra[8:7] == 2'b00) begin
      rd_val[intc_pkg::SMR_PRIO_LSB +: 3] = q.prio[ra[6:2]];
      rd_val[intc_pkg::SMR_TYPE_LSB +: 2] = q.typ[ra[6:2]];
    end else if (ra[8:7] == 2'b01) begin
      rd_val = q.svr[ra[6:2]];
    end else begin
      case (ra)
        intc_pkg::IVR_OFS:  rd_val = irq_raw ? q.svr[arb.idx] : q.spu;
        intc_pkg::FVR_OFS:  rd_val = fast_raw ? q.svr[0] : q.spu;
        intc_pkg::ISR_OFS:  rd_val = {27'h0, cur_src};
        intc_pkg::IPR_OFS:  rd_val = ipr;
        intc_pkg::IMR_OFS:  rd_val = q.imr;
        intc_pkg::CISR_OFS: begin
          rd_val[intc_pkg::CISR_FAST_BIT] = !q.fast_n;
          rd_val[intc_pkg::CISR_IRQ_BIT] = !q.irq_n;
        end
        intc_pkg::SPU_OFS:  rd_val = q.spu;
        intc_pkg::DCR_OFS: begin
          rd_val[intc_pkg::DCR_PROT_BIT] = q.prot;
          rd_val[intc_pkg::DCR_GMSK_BIT] = q.gmsk;
        end
        intc_pkg::FFSR_OFS: rd_val = ff_all;
        default:            rd_val = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Side effects
  // ****************************************
  logic         ivr_take, fvr_take, push, pop;
  logic [N-1:0] set_m, clr_m, sw_set, sw_clr, auto_clr;

  assign ivr_take = (rd_go && ra == intc_pkg::IVR_OFS && rd_ok && !q.prot) ||
                    (wr_hit && q.waddr == intc_pkg::IVR_OFS && q.prot);
  assign fvr_take = (rd_go && ra == intc_pkg::FVR_OFS && rd_ok && !q.prot) ||
                    (wr_hit && q.waddr == intc_pkg::FVR_OFS && q.prot);
  assign push     = ivr_take && irq_raw && q.depth < 4'(L);
  assign pop      = wr_hit && q.waddr == intc_pkg::EOICR_OFS && q.depth != 4'd0;
  assign sw_set   = (wr_hit && q.waddr == intc_pkg::ISCR_OFS) ? q.wdata : '0;
  assign sw_clr   = (wr_hit && q.waddr == intc_pkg::ICCR_OFS) ? q.wdata : '0;
  assign auto_clr = ((ivr_take && irq_raw) ? ({{(N-1){1'b0}}, 1'b1} << arb.idx) : '0)
                  | {{(N-1){1'b0}}, fvr_take};
  assign set_m    = em & (rise | sw_set);
  assign clr_m    = em & (sw_clr | auto_clr);

  // ****************************************
  // Next state
  // ****************************************
  logic [31:0] smr_w;
  logic [4:0]  wi;
  logic [2:0]  pidx;

  always_comb begin
    n     = q;
    wi    = q.waddr[6:2];
    smr_w = 32'h0000_0000;
    pidx  = 3'(q.depth - {3'h0, pop});
    n.s1  = pin_raw;
    n.s2  = q.s1;
    n.s3  = q.s2;
    n.filt = (q.s3 & ~(q.s2 ^ q.s3)) | (q.filt & (q.s2 ^ q.s3));
    n.prev = act;
    n.edg  = (q.edg & ~clr_m) | set_m;
    if (push) begin
      n.slvl[pidx] = arb.lvl;
      n.ssrc[pidx] = arb.idx;
    end
    n.depth = q.depth + {3'h0, push} - {3'h0, pop};
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      n.aw_have = 1'b1;
      n.waddr   = s_axi_awaddr_in[8:0];
      n.wbad    = s_axi_awaddr_in[31:9] != 23'h0;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      n.w_have = 1'b1;
      n.wdata  = s_axi_wdata_in;
      n.wstrb  = s_axi_wstrb_in;
    end
    if (wr_go) begin
      n.aw_have = 1'b0;
      n.w_have  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = wr_hit ? intc_pkg::RESP_OKAY : intc_pkg::RESP_SLVERR;
    end else if (q.bvalid && s_axi_bready_in) begin
      n.bvalid = 1'b0;
    end
    if (wr_hit) begin
      if (q.waddr[8:7] == 2'b00) begin
        smr_w[intc_pkg::SMR_PRIO_LSB +: 3] = q.prio[wi];
        smr_w[intc_pkg::SMR_TYPE_LSB +: 2] = q.typ[wi];
        smr_w      = wmerge(smr_w, q.wdata, q.wstrb);
        n.prio[wi] = smr_w[intc_pkg::SMR_PRIO_LSB +: 3];
        n.typ[wi]  = intc_pkg::src_type_t'(smr_w[intc_pkg::SMR_TYPE_LSB +: 2]);
      end else if (q.waddr[8:7] == 2'b01) begin
        n.svr[wi] = wmerge(q.svr[wi], q.wdata, q.wstrb);
      end else begin
        case (q.waddr)
          intc_pkg::IECR_OFS: n.imr = q.imr | q.wdata;
          intc_pkg::IDCR_OFS: n.imr = q.imr & ~q.wdata;
          intc_pkg::SPU_OFS:  n.spu = wmerge(q.spu, q.wdata, q.wstrb);
          intc_pkg::DCR_OFS: begin
            n.prot = q.wdata[intc_pkg::DCR_PROT_BIT];
            n.gmsk = q.wdata[intc_pkg::DCR_GMSK_BIT];
          end
          intc_pkg::FFER_OFS: n.ffr = q.ffr | q.wdata;
          intc_pkg::FFDR_OFS: n.ffr = q.ffr & ~q.wdata;
          default: ;
        endcase
      end
    end
    if (rd_go) begin
      n.rvalid = 1'b1;
      n.rdata  = rd_ok ? rd_val : 32'h0000_0000;
      n.rresp  = rd_ok ? intc_pkg::RESP_OKAY : intc_pkg::RESP_SLVERR;
    end else if (q.rvalid && s_axi_rready_in) begin
      n.rvalid = 1'b0;
    end
    n.fast_n = !(fast_raw && !q.gmsk);
    n.irq_n = !(irq_raw && !q.gmsk);
    n.wake  = fast_raw || irq_raw;
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      q       <= '0;
      q.spu   <= intc_pkg::SPU_RST;
      // Idle-high pins read inactive in the default low-level mode
      q.s1     <= '1;
      q.s2     <= '1;
      q.s3     <= '1;
      q.filt   <= '1;
      q.fast_n <= 1'b1;
      q.irq_n <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign s_axi_bresp_out      = q.bresp;
  assign s_axi_bvalid_out     = q.bvalid;
  assign s_axi_rdata_out      = q.rdata;
  assign s_axi_rresp_out      = q.rresp;
  assign s_axi_rvalid_out     = q.rvalid;
  assign fast_request_out_n   = q.fast_n;
  assign normal_request_out_n = q.irq_n;
  assign idle_wake_out        = q.wake;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  property p_rst_high;
    @(posedge sys_clk_in) disable iff (1'b0)
      sys_rst_in |=> fast_request_out_n && normal_request_out_n;
  endproperty
  a_rst_high: assert property (p_rst_high) else $error("request low after reset");

  property p_fast;
    fast_raw && !q.gmsk |=> !fast_request_out_n;
  endproperty
  a_fast: assert property (p_fast) else $error("fast request not driven");

  property p_gmsk_wake;
    (fast_raw || irq_raw) && q.gmsk |=> idle_wake_out && fast_request_out_n
                                       && normal_request_out_n;
  endproperty
  a_gmsk_wake: assert property (p_gmsk_wake) else $error("mask wake wrong");

  property p_normal_wake;
    !normal_request_out_n |-> idle_wake_out;
  endproperty
  a_normal_wake: assert property (p_normal_wake) else $error("no wake on request");

  sequence s_ivr_take;
    rd_go && rd_ok && ra == intc_pkg::IVR_OFS && !q.prot && irq_raw && q.depth < 4'd8 && !pop;
  endsequence
  sequence s_pushed(logic [3:0] d);
    q.depth == d + 4'd1 ##0 s_axi_rvalid_out;
  endsequence
  property p_nest;
    logic [3:0] d;
    (s_ivr_take, d = q.depth) |=> s_pushed(d);
  endproperty
  a_nest: assert property (p_nest) else $error("vector read did not nest");

  property p_prot;
    rd_go && q.prot && !wr_go |=> (($past(q.edg) & ~q.edg) == '0) && $stable(q.depth);
  endproperty
  a_prot: assert property (p_prot) else $error("protect read had effect");

  property p_enable;
    logic [31:0] m;
    (wr_hit && q.waddr == intc_pkg::IECR_OFS, m = q.wdata) |=> (q.imr & m) == m;
  endproperty
  a_enable: assert property (p_enable) else $error("enable command lost");

  property p_level_clear;
    logic [31:0] m;
    (wr_hit && (q.waddr == intc_pkg::ICCR_OFS || q.waddr == intc_pkg::ISCR_OFS), m = ~em)
      |=> ((q.edg ^ $past(q.edg)) & m) == '0;
  endproperty
  a_level_clear: assert property (p_level_clear) else $error("clear hit level source");

  property p_unmapped;
    rd_go && !rd_ok |=> s_axi_rvalid_out && s_axi_rresp_out == intc_pkg::RESP_SLVERR;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read answered okay");
endmodule
`default_nettype wire

// *** test/core_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module core_model (
  input  wire logic clk_in,
  input  wire logic fast_n_in,
  input  wire logic normal_n_in,
  input  wire logic wake_in,
  output logic      idle_out
);
  // ****************************************
  // Core sleeps until a request or wake
  // ****************************************
  always_ff @(posedge clk_in) begin
    idle_out <= fast_n_in && normal_n_in && !wake_in;
  end
endmodule
`default_nettype wire

// *** test/test_vectored_priority_interrupt_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_vectored_priority_interrupt_ctrl;
  // ****************************************
  // Signals
  // ****************************************
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdat, d;
  logic [31:0] ext = 32'hFFFF_FFFF;
  logic [31:0] per = '0;
  logic [3:0]  system_source = '0;
  logic        aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_rdy = 1'b0, fpin = 1'b1;
  logic        aw_r, w_r, b_v, ar_r, r_v, fq_n, nq_n, wake, idle;
  logic [1:0]  bresp, rresp, resp;
  int          miscompares = 0;
  int          samples_checked = 0;

  always #50 clk = ~clk;

  vectored_priority_interrupt_ctrl dut (
    .sys_clk_in(clk), .sys_rst_in(rst), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(aw_v),
    .s_axi_awready_out(aw_r), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF),
    .s_axi_wvalid_in(w_v), .s_axi_wready_out(w_r), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(b_v), .s_axi_bready_in(b_r), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(ar_v), .s_axi_arready_out(ar_r), .s_axi_rdata_out(rdat),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(r_v), .s_axi_rready_in(r_rdy),
    .fast_request_pin_in(fpin), .external_request_pins_in(ext), .system_irq_in(system_source),
    .peripheral_irq_in(per), .fast_request_out_n(fq_n), .normal_request_out_n(nq_n),
    .idle_wake_out(wake));

  core_model core (.clk_in(clk), .fast_n_in(fq_n), .normal_n_in(nq_n), .wake_in(wake),
    .idle_out(idle));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [8:0] smr(int i);
    return intc_pkg::SMR_BASE + 9'(4 * i);
  endfunction
  function automatic logic [8:0] svr(int i);
    return intc_pkg::SVR_BASE + 9'(4 * i);
  endfunction
  function automatic logic [31:0] vec(int i);
    return 32'hC0DE_0000 | 32'(i);
  endfunction
  function automatic logic [31:0] mode(intc_pkg::src_type_t t, int p);
    return (32'(t) << intc_pkg::SMR_TYPE_LSB) | 32'(p);
  endfunction

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic hang(input string what);
    miscompares++;
    $display("BAD %s expected answer seen none", what);
    close_out();
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic wr(input logic [8:0] a, input logic [31:0] v);
    int n;
    logic ah, wh, bh;
    awaddr <= {23'h0, a};
    wdata <= v;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge clk);
      ah = aw_v && aw_r;
      wh = w_v && w_r;
      bh = b_v && b_r;
      resp = bresp;
      @(posedge clk);
      if (ah) aw_v <= 1'b0;
      if (wh) w_v <= 1'b0;
      if (bh) break;
    end
    if (n == 50) hang("write");
  endtask

  task automatic rd(input logic [8:0] a);
    int n;
    logic ah, rh;
    araddr <= {23'h0, a};
    ar_v <= 1'b1;
    r_rdy <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge clk);
      ah = ar_v && ar_r;
      rh = r_v && r_rdy;
      d = rdat;
      resp = rresp;
      @(posedge clk);
      if (ah) ar_v <= 1'b0;
      if (rh) break;
    end
    if (n == 50) hang("read");
  endtask

  task automatic rc(input logic [8:0] a, input logic [31:0] e);
    rd(a);
    chk($sformatf("reg %h", a), e, d);
  endtask

  // Waits for wake, normal, fast to settle at the expected pattern
  task automatic waitp(input logic [2:0] e);
    logic [2:0] p;
    for (int n = 0; n < 12; n++) begin
      @(negedge clk);
      p = {wake, nq_n, fq_n};
      if (p === e) break;
    end
    @(posedge clk);
    chk("wake_normal_fast", 32'(e), 32'(p));
  endtask

  task automatic idle_chk;
    @(negedge clk);
    chk("core_idle", 32'h0, 32'(idle));
    @(posedge clk);
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    waitp(3'b011);
    rc(intc_pkg::IMR_OFS, 32'h0);
    rc(intc_pkg::IPR_OFS, 32'h0);
    rc(intc_pkg::IVR_OFS, intc_pkg::SPU_RST);
    rc(9'h1FC, 32'h0);
    chk("resp", 32'(intc_pkg::RESP_SLVERR), 32'(resp));
    wr(9'h1FC, 32'h0000_0001);
    chk("bresp", 32'(intc_pkg::RESP_SLVERR), 32'(resp));
    wr(intc_pkg::SPU_OFS, 32'h0000_BEEF);
    rc(intc_pkg::IVR_OFS, 32'h0000_BEEF);
    for (int i = 0; i < 32; i++) wr(svr(i), vec(i));
    chk("bresp", 32'(intc_pkg::RESP_OKAY), 32'(resp));
    rc(svr(31), vec(31));
    $display("test reset done");

    wr(smr(5), mode(intc_pkg::TYP_HIGH_LEVEL, 3));
    wr(smr(7), mode(intc_pkg::TYP_HIGH_LEVEL, 5));
    per[5] <= 1'b1;
    rc(intc_pkg::IPR_OFS, 32'h0000_0020);
    wr(intc_pkg::IECR_OFS, 32'h0000_0020);
    waitp(3'b101);
    idle_chk();
    rc(intc_pkg::IMR_OFS, 32'h0000_0020);
    rc(intc_pkg::CISR_OFS, 32'h0000_0002);
    rc(intc_pkg::IVR_OFS, vec(5));
    rc(intc_pkg::ISR_OFS, 32'h5);
    per[7] <= 1'b1;
    wr(intc_pkg::IECR_OFS, 32'h0000_0080);
    waitp(3'b101);
    rc(intc_pkg::IVR_OFS, vec(7));
    wr(intc_pkg::EOICR_OFS, 32'h0);
    wr(intc_pkg::EOICR_OFS, 32'h0);
    wr(intc_pkg::IDCR_OFS, 32'h0000_00A0);
    per[7] <= 1'b0;
    waitp(3'b011);
    $display("test level done");

    wr(smr(8), mode(intc_pkg::TYP_RISE_EDGE, 1));
    wr(intc_pkg::ISCR_OFS, 32'h0000_0100);
    rc(intc_pkg::IPR_OFS, 32'h0000_0120);
    wr(intc_pkg::IECR_OFS, 32'h0000_0100);
    waitp(3'b101);
    rc(intc_pkg::IVR_OFS, vec(8));
    wr(intc_pkg::EOICR_OFS, 32'h0);
    rc(intc_pkg::IPR_OFS, 32'h0000_0020);
    wr(smr(9), mode(intc_pkg::TYP_HIGH_LEVEL, 1));
    wr(intc_pkg::ISCR_OFS, 32'h0000_0200);
    rc(intc_pkg::IPR_OFS, 32'h0000_0020);
    wr(intc_pkg::DCR_OFS, 32'h0000_0001);
    wr(intc_pkg::ISCR_OFS, 32'h0000_0100);
    waitp(3'b101);
    rc(intc_pkg::IVR_OFS, vec(8));
    rc(intc_pkg::IPR_OFS, 32'h0000_0120);
    wr(intc_pkg::IVR_OFS, 32'h0);
    rc(intc_pkg::ISR_OFS, 32'h8);
    rc(intc_pkg::IPR_OFS, 32'h0000_0020);
    wr(intc_pkg::EOICR_OFS, 32'h0);
    wr(intc_pkg::ICCR_OFS, 32'h0000_0100);
    rc(intc_pkg::IPR_OFS, 32'h0000_0020);
    wr(intc_pkg::DCR_OFS, 32'h0);
    wr(intc_pkg::IDCR_OFS, 32'h0000_0100);
    $display("test edge done");

    wr(intc_pkg::FFER_OFS, 32'h0000_0020);
    wr(intc_pkg::IECR_OFS, 32'h0000_0020);
    waitp(3'b110);
    rc(intc_pkg::FFSR_OFS, 32'h0000_0021);
    rc(intc_pkg::CISR_OFS, 32'h0000_0001);
    wr(intc_pkg::IDCR_OFS, 32'h0000_0020);
    wr(intc_pkg::FFDR_OFS, 32'h0000_0020);
    wr(smr(0), mode(intc_pkg::TYP_HIGH_LEVEL, 0));
    wr(intc_pkg::IECR_OFS, 32'h0000_0001);
    waitp(3'b110);
    rc(intc_pkg::FVR_OFS, vec(0));
    wr(intc_pkg::IDCR_OFS, 32'h0000_0001);
    waitp(3'b011);
    $display("test fast done");

    wr(smr(1), mode(intc_pkg::TYP_HIGH_LEVEL, 2));
    system_source <= 4'b0100;
    wr(intc_pkg::IECR_OFS, 32'h0000_0002);
    waitp(3'b101);
    rc(intc_pkg::IVR_OFS, vec(1));
    rc(intc_pkg::ISR_OFS, 32'h1);
    wr(intc_pkg::EOICR_OFS, 32'h0);
    wr(intc_pkg::IDCR_OFS, 32'h0000_0002);
    system_source <= 4'b0000;
    for (int k = 0; k < 4; k++) begin
      wr(smr(25), mode(intc_pkg::src_type_t'(k[1:0]), 4));
      ext[25] <= ~k[1];
      repeat (5) @(posedge clk);
      wr(intc_pkg::ICCR_OFS, 32'h0200_0000);
      wr(intc_pkg::IECR_OFS, 32'h0200_0000);
      ext[25] <= k[1];
      waitp(3'b101);
      rc(intc_pkg::IVR_OFS, vec(25));
      wr(intc_pkg::EOICR_OFS, 32'h0);
      wr(intc_pkg::IDCR_OFS, 32'h0200_0000);
    end
    ext[25] <= 1'b1;
    $display("test sources done");

    wr(intc_pkg::DCR_OFS, 32'h0000_0002);
    wr(intc_pkg::IECR_OFS, 32'h0000_0020);
    waitp(3'b111);
    idle_chk();
    wr(intc_pkg::DCR_OFS, 32'h0);
    waitp(3'b101);
    wr(intc_pkg::IDCR_OFS, 32'h0000_0020);
    per[5] <= 1'b0;
    waitp(3'b011);
    $display("test mask done");
    close_out();
  end
endmodule
`default_nettype wire
